/* rtl/cstf_can_status_regs.sv */
// status, frame format and bit timing registers of the can controller
//
// Operation
// R1 - bus_off_flag follows entering and leaving bus-off (tx count above 255).
// R2 - err_passive_flag follows entering and leaving error-passive (count above 127).
// R3 - bus_error_flag sets on any bus error, clears on next good frame.
// R4 - dual_buffer_status is enable AND slots 14, 15 set for data reception.
// R5 - self_rx_status follows the written self_rx_enable control.
// R6 - engine_reset_status high while engine in reset, cleared by writing control 0.
// R7 - rx_role_flag set when receiving, cleared on transmit start or bus idle.
// R8 - tx_role_flag set when transmitting, cleared on receive start or bus idle.
// R9 - rx_done_flag sets on good reception, clears on good transmission.
// R10 - tx_done_flag sets on good transmission, clears on good reception.
// R11 - done_slot_number loads last completed slot; software cannot clear it.
// R12 - sixteen slot_format_bit bits, 0 standard, 1 extended, reset zero.
// R13 - software changes a format bit only while that slot is idle.
// R14 - resync_jump_width code 00..11 selects 1..4 time quanta.
// R15 - phase_seg_two_len code 001..111 selects 2..8 quanta; 000 forbidden.
// R16 - phase_seg_one_len code 000..111 selects 1..8 time quanta.
// R17 - prop_seg_len at bits 5..7, codes select 1..8 time quanta.
// R18 - single sample at phase one end, or majority of three quanta.
// R19 - software keeps bit 8..25 quanta, jump width within both phases.
// R20 - writes to controller_state are ignored.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module cstf_can_status_regs
    import cstf_pkg::*;
(
    input wire logic i_clk, // system clock, 20 MHz
    input wire logic i_rst, // async reset, high
    // axi4-lite slave
    input wire logic [31:0] i_awaddr, // write address
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [31:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // write byte lanes
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    output logic [1:0] o_bresp, // write response
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    input wire logic [31:0] i_araddr, // read address
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    output logic [31:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_rvalid, // read data valid
    input wire logic i_rready, // read data ready
    // protocol engine events, same clock
    input wire logic i_bus_off_state, // engine is bus-off
    input wire logic i_err_passive_state, // engine is error-passive
    input wire logic i_bus_err_evt, // pulse: error seen on bus
    input wire logic i_rx_ok_evt, // pulse: frame received without error
    input wire logic i_tx_ok_evt, // pulse: frame sent without error
    input wire logic i_rx_start_evt, // pulse: node starts as receiver
    input wire logic i_tx_start_evt, // pulse: node starts as transmitter
    input wire logic i_bus_idle_evt, // pulse: bus became idle
    input wire logic i_slot_load_evt, // pulse: slot finished tx or rx store
    input wire logic [3:0] i_slot_num, // slot number with i_slot_load_evt
    input wire logic i_engine_in_reset, // engine held in reset
    input wire logic i_slot14_rx_data, // slot 14 set for data reception
    input wire logic i_slot15_rx_data, // slot 15 set for data reception
    input wire logic i_tq_tick, // pulse per time quantum
    input wire logic i_sample_pt, // pulse at end of phase segment one
    input wire logic i_can_rx, // bus receive pin, asynchronous
    // controls towards the engine
    output logic o_engine_reset_req, // protocol reset control
    output logic o_dual_buffer_enable, // dual-buffer receive control
    output logic o_self_rx_enable, // self-receive control
    output logic [15:0] o_slot_format, // per-slot format, 1 extended
    output logic [2:0] o_sjw_tq, // jump width in quanta
    output logic [3:0] o_ph2_tq, // phase two in quanta
    output logic [3:0] o_ph1_tq, // phase one in quanta
    output logic [3:0] o_prop_tq, // propagation in quanta
    output logic o_rx_bit, // sampled bus bit
    output logic o_rx_bit_vld // pulse with new sampled bit
);
    // ==========================================================
    // bus slave state
    logic aw_full_r;
    logic w_full_r;
    logic [29:0] aw_idx_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    logic wr_go;
    logic wr_hit;
    logic [15:0] ctrl_r;
    logic [15:0] format_r;
    logic [15:0] timing_r;
    logic [15:0] state_rd;
    logic [1:0] rx_sync_r;
    logic ctl_wr;

    // ==========================================================
    // write channel: address and data taken in either order
    assign wr_go = aw_full_r && w_full_r && !o_bvalid;
    assign wr_hit = (aw_idx_r == CSTF_IDX_CTRL) || (aw_idx_r == CSTF_IDX_FORMAT)
        || (aw_idx_r == CSTF_IDX_TIMING) || (aw_idx_r == CSTF_IDX_STATE);
    assign ctl_wr = wr_go && (aw_idx_r == CSTF_IDX_CTRL) && wstrb_r[0];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_full_r <= 1'b0;
            aw_idx_r <= 30'h0;
            o_awready <= 1'b0;
        end else begin
            o_awready <= !aw_full_r && !o_awready;
            if (o_awready && i_awvalid) begin
                aw_full_r <= 1'b1;
                aw_idx_r <= i_awaddr[31:2];
                o_awready <= 1'b0;
            end else if (wr_go) begin
                aw_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            w_full_r <= 1'b0;
            wdata_r <= 16'h0;
            wstrb_r <= 2'b00;
            o_wready <= 1'b0;
        end else begin
            o_wready <= !w_full_r && !o_wready;
            if (o_wready && i_wvalid) begin
                w_full_r <= 1'b1;
                wdata_r <= i_wdata[15:0];
                wstrb_r <= i_wstrb[1:0];
                o_wready <= 1'b0;
            end else if (wr_go) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // write response, slave error for unmapped addresses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= CSTF_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? CSTF_RESP_OKAY : CSTF_RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // software registers, byte lanes honoured
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= CSTF_RST_CTRL;
            format_r <= CSTF_RST_FORMAT;
            timing_r <= CSTF_RST_TIMING;
        end else if (wr_go) begin
            // only the three control bits exist; the rest stay zero
            if (ctl_wr) begin
                ctrl_r[CSTF_CTL_DUAL] <= wdata_r[CSTF_CTL_DUAL];
                ctrl_r[CSTF_CTL_SELF] <= wdata_r[CSTF_CTL_SELF];
                ctrl_r[CSTF_CTL_RST] <= wdata_r[CSTF_CTL_RST];
            end
            if (aw_idx_r == CSTF_IDX_FORMAT) begin
                if (wstrb_r[0]) format_r[7:0] <= wdata_r[7:0]; // R12
                if (wstrb_r[1]) format_r[15:8] <= wdata_r[15:8]; // R12
            end
            if (aw_idx_r == CSTF_IDX_TIMING) begin
                if (wstrb_r[0]) timing_r[7:0] <= wdata_r[7:0] & CSTF_TM_MASK[7:0];
                if (wstrb_r[1]) timing_r[15:8] <= wdata_r[15:8];
            end
            // a write to the state index is acknowledged and dropped
        end
    end

    // ==========================================================
    // controller state flags driven by engine events and the control register
    logic bus_off_flag_r, err_passive_flag_r, bus_error_flag_r, dual_buffer_status_r;
    logic self_rx_status_r, engine_reset_status_r, rx_role_flag_r, tx_role_flag_r;
    logic rx_done_flag_r, tx_done_flag_r;
    logic [3:0] done_slot_number_r;

    // error confinement levels
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_off_flag_r <= 1'b0;
            err_passive_flag_r <= 1'b0;
        end else begin
            bus_off_flag_r <= i_bus_off_state; // R1
            err_passive_flag_r <= i_err_passive_state; // R2
        end
    end

    // bus error: a new error beats a good frame in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_error_flag_r <= 1'b0;
        end else if (i_bus_err_evt) begin
            bus_error_flag_r <= 1'b1; // R3
        end else if (i_rx_ok_evt || i_tx_ok_evt) begin
            bus_error_flag_r <= 1'b0; // R3
        end
    end

    // mode status; software writes never touch these directly
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dual_buffer_status_r <= 1'b0;
            self_rx_status_r <= 1'b0;
        end else begin
            dual_buffer_status_r <= ctrl_r[CSTF_CTL_DUAL] && i_slot14_rx_data
                && i_slot15_rx_data; // R4
            self_rx_status_r <= ctrl_r[CSTF_CTL_SELF]; // R5
        end
    end

    // engine reset status; a reset still in force wins over the write of 0
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            engine_reset_status_r <= CSTF_RST_STATE[CSTF_ST_ERST];
        end else if (i_engine_in_reset) begin
            engine_reset_status_r <= 1'b1; // R6
        end else if (ctl_wr && !wdata_r[CSTF_CTL_RST]) begin
            engine_reset_status_r <= 1'b0; // R6
        end
    end

    // node role
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_role_flag_r <= 1'b0;
            tx_role_flag_r <= 1'b0;
        end else begin
            if (i_rx_start_evt) begin
                rx_role_flag_r <= 1'b1; // R7
            end else if (i_tx_start_evt || i_bus_idle_evt) begin
                rx_role_flag_r <= 1'b0; // R7
            end
            if (i_tx_start_evt) begin
                tx_role_flag_r <= 1'b1; // R8
            end else if (i_rx_start_evt || i_bus_idle_evt) begin
                tx_role_flag_r <= 1'b0; // R8
            end
        end
    end

    // completion flags, each set beats the other event's clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_done_flag_r <= 1'b0;
            tx_done_flag_r <= 1'b0;
        end else begin
            if (i_rx_ok_evt) begin
                rx_done_flag_r <= 1'b1; // R9
            end else if (i_tx_ok_evt) begin
                rx_done_flag_r <= 1'b0; // R9
            end
            if (i_tx_ok_evt) begin
                tx_done_flag_r <= 1'b1; // R10
            end else if (i_rx_ok_evt) begin
                tx_done_flag_r <= 1'b0; // R10
            end
        end
    end

    // last completed slot, loaded only by the engine
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done_slot_number_r <= CSTF_RST_STATE[3:0];
        end else if (i_slot_load_evt) begin
            done_slot_number_r <= i_slot_num; // R11
        end
    end

    // assembled controller_state, read only
    always_comb begin
        state_rd = 16'h0000; // R20
        state_rd[CSTF_ST_BOFF] = bus_off_flag_r;
        state_rd[CSTF_ST_EPAS] = err_passive_flag_r;
        state_rd[CSTF_ST_BERR] = bus_error_flag_r;
        state_rd[CSTF_ST_DUAL] = dual_buffer_status_r;
        state_rd[CSTF_ST_SELF] = self_rx_status_r;
        state_rd[CSTF_ST_ERST] = engine_reset_status_r;
        state_rd[CSTF_ST_RXR] = rx_role_flag_r;
        state_rd[CSTF_ST_TXR] = tx_role_flag_r;
        state_rd[CSTF_ST_RXD] = rx_done_flag_r;
        state_rd[CSTF_ST_TXD] = tx_done_flag_r;
        state_rd[CSTF_ST_SLOT +: 4] = done_slot_number_r;
    end

    // ==========================================================
    // read channel, one cycle from address to data
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= CSTF_RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !o_arready;
            if (o_arready && i_arvalid) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rresp <= CSTF_RESP_OKAY;
                case (i_araddr[31:2])
                    CSTF_IDX_CTRL: o_rdata <= {16'h0, ctrl_r};
                    CSTF_IDX_STATE: o_rdata <= {16'h0, state_rd};
                    CSTF_IDX_FORMAT: o_rdata <= {16'h0, format_r};
                    CSTF_IDX_TIMING: o_rdata <= {16'h0, timing_r};
                    default: begin
                        o_rdata <= 32'h0;
                        o_rresp <= CSTF_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // controls and decoded timing towards the engine
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_engine_reset_req <= CSTF_RST_CTRL[CSTF_CTL_RST];
            o_dual_buffer_enable <= CSTF_RST_CTRL[CSTF_CTL_DUAL];
            o_self_rx_enable <= CSTF_RST_CTRL[CSTF_CTL_SELF];
            o_slot_format <= CSTF_RST_FORMAT;
            o_sjw_tq <= 3'h1;
            o_ph2_tq <= 4'h1;
            o_ph1_tq <= 4'h1;
            o_prop_tq <= 4'h1;
        end else begin
            o_engine_reset_req <= ctrl_r[CSTF_CTL_RST];
            o_dual_buffer_enable <= ctrl_r[CSTF_CTL_DUAL];
            o_self_rx_enable <= ctrl_r[CSTF_CTL_SELF];
            o_slot_format <= format_r; // R12
            o_sjw_tq <= {1'b0, timing_r[CSTF_TM_SJW +: 2]} + CSTF_TQ_ONE[2:0]; // R14
            // code 000 is forbidden; it decodes to one quantum, never used
            o_ph2_tq <= {1'b0, timing_r[CSTF_TM_PH2 +: 3]} + CSTF_TQ_ONE; // R15
            o_ph1_tq <= {1'b0, timing_r[CSTF_TM_PH1 +: 3]} + CSTF_TQ_ONE; // R16
            o_prop_tq <= {1'b0, timing_r[CSTF_TM_PRB +: 3]} + CSTF_TQ_ONE; // R17
        end
    end

    // ==========================================================
    // bus pin synchroniser and sampler
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_sync_r <= 2'b11;
        end else begin
            rx_sync_r <= {rx_sync_r[0], i_can_rx};
        end
    end

    cstf_bit_sampler u_sampler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tq_tick(i_tq_tick),
        .i_sample_pt(i_sample_pt),
        .i_rx_bit(rx_sync_r[1]),
        .i_vote_sel(timing_r[CSTF_TM_SAM]), // R18
        .o_bit(o_rx_bit),
        .o_bit_vld(o_rx_bit_vld)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_ctl_write(bit v);
        ctl_wr && (wdata_r[CSTF_CTL_SELF] == v);
    endsequence

    AST_BUS_OFF: assert property (i_bus_off_state |=> bus_off_flag_r) // R1
        else $error("bus-off flag missed");
    AST_ERR_PASSIVE: assert property ($fell(i_err_passive_state) |=> !err_passive_flag_r) // R2
        else $error("error-passive flag not dropped");
    AST_BUS_ERR: assert property ((!i_bus_err_evt && i_rx_ok_evt) ##1 1 |-> !bus_error_flag_r) // R3
        else $error("bus error not cleared by good frame");
    AST_DUAL_BUF: assert property (dual_buffer_status_r |-> $past(ctrl_r[CSTF_CTL_DUAL])) // R4
        else $error("dual buffer status without enable");
    AST_SELF_RX: assert property (s_ctl_write(1'b1) |=> ##1 self_rx_status_r) // R5
        else $error("self receive status not set");
    AST_ENGINE_RST: assert property (i_engine_in_reset |=> engine_reset_status_r ##1 // R6
        engine_reset_status_r || !$past(i_engine_in_reset))
        else $error("engine reset status lost");
    AST_ROLE: assert property (i_tx_start_evt && !i_rx_start_evt |=> // R7
        tx_role_flag_r && !rx_role_flag_r)
        else $error("role flags wrong after transmit start");
    AST_DONE: assert property (i_rx_ok_evt |=> rx_done_flag_r && // R9
        (tx_done_flag_r == $past(i_tx_ok_evt)))
        else $error("completion flags wrong after reception");
    AST_SLOT_HOLD: assert property (!i_slot_load_evt |=> $stable(done_slot_number_r)) // R11
        else $error("slot number changed without load");
    AST_STATE_RO: assert property (wr_go && aw_idx_r == CSTF_IDX_STATE && // R20
        !i_slot_load_evt |=> $stable(done_slot_number_r))
        else $error("state write altered slot number");
endmodule

/* rtl/cstf_pkg.sv */
// package of register map, field layout and reset values for the can status block
package cstf_pkg;
    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [29:0] CSTF_IDX_CTRL = 30'h00801000;
    localparam logic [29:0] CSTF_IDX_STATE = 30'h00801002;
    localparam logic [29:0] CSTF_IDX_FORMAT = 30'h00801004;
    localparam logic [29:0] CSTF_IDX_TIMING = 30'h00801006;

    // ==========================================================
    // reset values
    localparam logic [15:0] CSTF_RST_CTRL = 16'h0001;
    localparam logic [15:0] CSTF_RST_STATE = 16'h0100;
    localparam logic [15:0] CSTF_RST_FORMAT = 16'h0000;
    localparam logic [15:0] CSTF_RST_TIMING = 16'h0000;

    // ==========================================================
    // control register fields
    localparam int CSTF_CTL_DUAL = 3;
    localparam int CSTF_CTL_SELF = 1;
    localparam int CSTF_CTL_RST = 0;

    // ==========================================================
    // controller state fields
    localparam int CSTF_ST_BOFF = 14;
    localparam int CSTF_ST_EPAS = 13;
    localparam int CSTF_ST_BERR = 12;
    localparam int CSTF_ST_DUAL = 11;
    localparam int CSTF_ST_SELF = 9;
    localparam int CSTF_ST_ERST = 8;
    localparam int CSTF_ST_RXR = 7;
    localparam int CSTF_ST_TXR = 6;
    localparam int CSTF_ST_RXD = 5;
    localparam int CSTF_ST_TXD = 4;
    localparam int CSTF_ST_SLOT = 0;

    // ==========================================================
    // bit timing fields (lsb position) and code offsets in time quanta
    localparam int CSTF_TM_SJW = 14;
    localparam int CSTF_TM_PH2 = 11;
    localparam int CSTF_TM_PH1 = 8;
    localparam int CSTF_TM_PRB = 5;
    localparam int CSTF_TM_SAM = 4;
    localparam logic [15:0] CSTF_TM_MASK = 16'hfff0;
    localparam logic [3:0] CSTF_TQ_ONE = 4'h1;

    // ==========================================================
    // axi responses
    localparam logic [1:0] CSTF_RESP_OKAY = 2'b00;
    localparam logic [1:0] CSTF_RESP_SLVERR = 2'b10;
endpackage

/* rtl/cstf_bit_sampler.sv */
// bit sampler taking one sample or a three-sample majority at the sample point
`timescale 1ns/1ps
module cstf_bit_sampler
    import cstf_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, high
    input wire logic i_tq_tick, // one-cycle pulse per time quantum
    input wire logic i_sample_pt, // pulse at end of phase segment one
    input wire logic i_rx_bit, // synchronised bus level
    input wire logic i_vote_sel, // 1 selects three samples
    output logic o_bit, // sampled bit value
    output logic o_bit_vld // one-cycle pulse with new bit
);
    logic [1:0] hist_r; // samples taken one and two quanta earlier
    logic vote;

    // ==========================================================
    // history of earlier quanta, recessive after reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hist_r <= 2'b11;
        end else if (i_tq_tick) begin
            hist_r <= {hist_r[0], i_rx_bit};
        end
    end

    assign vote = (i_rx_bit & hist_r[0]) | (i_rx_bit & hist_r[1]) | (hist_r[0] & hist_r[1]);

    // decision at the sample point
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bit <= 1'b1;
            o_bit_vld <= 1'b0;
        end else begin
            o_bit_vld <= i_sample_pt;
            if (i_sample_pt) begin
                o_bit <= i_vote_sel ? vote : i_rx_bit; // R18
            end
        end
    end

    AST_SINGLE_SAMPLE: assert property (@(posedge i_clk) disable iff (i_rst) // R18
        (i_sample_pt && !i_vote_sel) |=> o_bit_vld && (o_bit == $past(i_rx_bit)))
        else $error("single sample differs from bus level");
endmodule

/* tb/cstf_engine_model.sv */
// stand-in for the protocol engine and bus: event pulses, ticks, pin
`timescale 1ns/1ps
module cstf_engine_model (
    input wire logic i_clk, // system clock
    input wire logic [6:0] i_kick, // event requests from bench
    output logic [6:0] o_evt, // one-cycle event pulses
    output logic o_tq, // quantum tick
    output logic o_sp, // sample point pulse
    output logic o_rx // bus level
);
    logic [3:0] cnt_r = 4'h0;
    // ==========================================
    // events leave one edge after the request, so pulses stay one cycle
    always_ff @(posedge i_clk) begin
        o_evt <= i_kick;
        cnt_r <= cnt_r + 4'h1;
        o_tq <= cnt_r[0];
        o_sp <= (cnt_r == 4'hb);
        o_rx <= cnt_r[3] ^ cnt_r[2]; // level moves, never parked
    end
endmodule

/* tb/cstf_can_status_regs_test.sv */
// self-checking bench for the can status, format and timing registers
`timescale 1ns/1ps
module cstf_can_status_regs_test
    import cstf_pkg::*;
;
    localparam logic [31:0] a_st = {CSTF_IDX_STATE, 2'b00};
    localparam logic [31:0] a_fm = {CSTF_IDX_FORMAT, 2'b00};
    localparam logic [31:0] a_tm = {CSTF_IDX_TIMING, 2'b00};
    localparam logic [31:0] a_ct = {CSTF_IDX_CTRL, 2'b00};
    logic clk = 1'b0, rst = 1'b1, boff = 1'b0, epas = 1'b0, eng_rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic s14 = 1'b0, s15 = 1'b0, tq, sp, can_rx, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0] wstrb = '0, slot = '0, ph2, ph1, prop;
    logic [6:0] kick = '0, evt;
    logic [1:0] bresp, rresp, bq[$];
    logic [2:0] resync_jump_width, ctl;
    logic [15:0] exp_st = CSTF_RST_STATE, d, fmt;
    logic [33:0] rq[$];
    int num_errors = 0, samples_checked = 0;
    integer seed = 32'he985;

    cstf_can_status_regs dut (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_bus_off_state(boff), .i_err_passive_state(epas), .i_bus_err_evt(evt[0]),
        .i_rx_ok_evt(evt[1]), .i_tx_ok_evt(evt[2]), .i_rx_start_evt(evt[3]),
        .i_tx_start_evt(evt[4]), .i_bus_idle_evt(evt[5]), .i_slot_load_evt(evt[6]),
        .i_slot_num(slot), .i_engine_in_reset(eng_rst), .i_slot14_rx_data(s14),
        .i_slot15_rx_data(s15), .i_tq_tick(tq), .i_sample_pt(sp), .i_can_rx(can_rx),
        .o_engine_reset_req(ctl[0]), .o_dual_buffer_enable(ctl[2]), .o_self_rx_enable(ctl[1]),
        .o_slot_format(fmt), .o_sjw_tq(resync_jump_width), .o_ph2_tq(ph2), .o_ph1_tq(ph1),
        .o_prop_tq(prop), .o_rx_bit(), .o_rx_bit_vld());
    cstf_engine_model eng (.i_clk(clk), .i_kick(kick), .o_evt(evt), .o_tq(tq),
        .o_sp(sp), .o_rx(can_rx));

    // ==========================================
    // clock and shared helpers
    initial forever #25 clk = ~clk;
    function automatic logic [15:0] b(input int i);
        return 16'h1 << i;
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
        rq.push_back({r, v});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
    endtask
    // pulse engine events, then read back the state with its new bits
    task automatic step(input logic [6:0] k, input logic [15:0] s, input logic [15:0] c);
        kick <= k;
        @(posedge clk) kick <= '0;
        repeat (3) @(posedge clk);
        exp_st = (exp_st & ~c) | s;
        rd(a_st, {16'h0, exp_st}, CSTF_RESP_OKAY);
    endtask
    // answers are compared in arrival order against the noted ones
    always @(posedge clk) begin
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        step('0, '0, '0);
        chk(ctl, 3'h1);
        rd(a_fm, 32'h0, CSTF_RESP_OKAY);
        rd(a_tm, 32'h0, CSTF_RESP_OKAY);
        rd(a_ct, {16'h0, CSTF_RST_CTRL}, CSTF_RESP_OKAY);
        wr(32'h4, 32'h1, CSTF_RESP_SLVERR);
        rd(32'h4, 32'h0, CSTF_RESP_SLVERR);
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 16'h0800 : (i == 1) ? 16'hffff : 16'($random(seed));
            d[10] = 1'b1;
            d[13:11] = d[10:8];
            wr(a_tm, {16'h0, d}, CSTF_RESP_OKAY);
            rd(a_tm, {16'h0, d & CSTF_TM_MASK}, CSTF_RESP_OKAY);
            chk({resync_jump_width, ph2, ph1, prop}, {3'(d[15:14] + 3'h1), 4'(d[13:11] + 4'h1),
                4'(d[10:8] + 4'h1), 4'(d[7:5] + 4'h1)});
            wr(a_fm, {16'h0, d}, CSTF_RESP_OKAY);
            rd(a_fm, {16'h0, d}, CSTF_RESP_OKAY);
            chk(fmt, d);
        end
        wr(a_st, 32'hffff, CSTF_RESP_OKAY);
        step('0, '0, '0);
        eng_rst <= 1'b0;
        s14 <= 1'b1;
        wr(a_ct, {16'h0, b(CSTF_CTL_DUAL) | b(CSTF_CTL_SELF)}, CSTF_RESP_OKAY);
        step('0, b(CSTF_ST_SELF), b(CSTF_ST_ERST));
        chk(ctl, 3'h6);
        s15 <= 1'b1;
        step('0, b(CSTF_ST_DUAL), '0);
        wr(a_ct, 32'h0, CSTF_RESP_OKAY);
        step('0, '0, b(CSTF_ST_DUAL) | b(CSTF_ST_SELF));
        chk(ctl, 3'h0);
        step(7'h10, b(CSTF_ST_TXR), '0);
        step(7'h08, b(CSTF_ST_RXR), b(CSTF_ST_TXR));
        step(7'h10, b(CSTF_ST_TXR), b(CSTF_ST_RXR));
        step(7'h01, b(CSTF_ST_BERR), '0);
        step(7'h02, b(CSTF_ST_RXD), b(CSTF_ST_BERR));
        d = 16'($random(seed));
        slot <= d[3:0];
        step(7'h44, b(CSTF_ST_TXD) | d[3:0], b(CSTF_ST_RXD) | 16'hf);
        step(7'h02, b(CSTF_ST_RXD), b(CSTF_ST_TXD));
        step(7'h20, '0, b(CSTF_ST_RXR) | b(CSTF_ST_TXR));
        wr(a_st, 32'h0, CSTF_RESP_OKAY);
        step('0, '0, '0);
        boff <= 1'b1;
        epas <= 1'b1;
        step('0, b(CSTF_ST_BOFF) | b(CSTF_ST_EPAS), '0);
        boff <= 1'b0;
        epas <= 1'b0;
        step('0, '0, b(CSTF_ST_BOFF) | b(CSTF_ST_EPAS));
        end_sim;
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim;
    end
endmodule
